// file: logic/eeprom_host.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Rules of the memory this block drives
// RL1 - Fifteen address lines select one byte
// RL2 - Select low for access, high saves power
// RL3 - Gate and select low start a read
// RL4 - Data floats when gate or select high
// RL5 - Write needs select, strobe low, gate high
// RL6 - Address taken at later falling strobe
// RL7 - Data taken at earlier rising strobe
// RL8 - Byte write finishes programming on its own
// RL9 - Page load holds one to 64 bytes
// RL10 - Later page bytes keep first page address
// RL11 - Next byte within 100 us, else programming
// RL12 - Status polls are ordinary read cycles
// RL13 - Bit seven reads inverted while programming
// RL14 - Illegal protected write gives no polling
// RL15 - Bit six flips per read while programming
// RL16 - Strobe pulses under 20 ns are ignored
// RL17 - Gate low or strobe high blocks writes
// RL18 - Delivered unprotected in standard mode
// RL19 - Protection sequence sets lasting protected state
// RL20 - Three unlock writes open one page
// RL21 - Unlock writes followed by real data write
// RL22 - Six writes clear protection after program_cycle_time
// RL23 - Gate may pulse between page byte loads
// RL24 - Sequence addresses and data are configurable
// ----------------------------------------------------------------
module eeprom_host import eeprom_host_pkg::*; #(
	parameter int BLC_CYC  = BLC_CYC_DEF,		// Byte load window in cycles
	parameter int PROG_CYC = WC_CYC_DEF,		// Longest program_cycle_time
	parameter logic [UNLOCK_LEN-1:0][ADDR_W-1:0] UNLOCK_ADDR = '{15'h0003, 15'h0002, 15'h0001},
	parameter logic [UNLOCK_LEN-1:0][DATA_W-1:0] UNLOCK_DATA = '{8'h03, 8'h02, 8'h01},
	parameter logic [CLEAR_LEN-1:0][ADDR_W-1:0]  CLEAR_ADDR  = '{15'h0006, 15'h0005, 15'h0004,
	                                                            15'h0003, 15'h0002, 15'h0001},
	parameter logic [CLEAR_LEN-1:0][DATA_W-1:0]  CLEAR_DATA  = '{8'h06, 8'h05, 8'h04,
	                                                            8'h03, 8'h02, 8'h01}
) (
	// Clock and reset
	input  wire logic              mclk,
	input  wire logic              rst,
	// Command
	input  wire logic              cmd_valid,
	output logic                   cmd_ready,
	input  wire op_e               cmd_op,
	input  wire logic [ADDR_W-1:0] cmd_addr,
	input  wire logic [DATA_W-1:0] cmd_wdata,
	input  wire logic              cmd_last,
	input  wire logic              cmd_protect,
	// Answer
	output logic                   rsp_valid,
	output logic [DATA_W-1:0]      rsp_rdata,
	output logic                   rsp_timeout,
	output logic                   busy,
	// Memory pins
	output logic [ADDR_W-1:0]      mem_addr,
	output logic                   mem_ce_n,
	output logic                   mem_oe_n,
	output logic                   mem_we_n,
	input  wire logic [DATA_W-1:0] mem_dq_i,
	output logic [DATA_W-1:0]      mem_dq_o,
	output logic                   mem_dq_oe
);

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		M_IDLE   = 4'b0000,
		M_READ   = 4'b0001,
		M_UNLOCK = 4'b0010,
		M_LOAD   = 4'b0011,
		M_SETTLE = 4'b0100,
		M_POLL   = 4'b0101,
		M_CLEAR  = 4'b0110,
		M_WAIT   = 4'b0111
	} main_e;

	localparam logic [TMR_W-1:0] OPEN_LIM   = TMR_W'(BLC_CYC - LOAD_GUARD_CYC);	// Last safe start
	localparam logic [TMR_W-1:0] SETTLE_LIM = TMR_W'(BLC_CYC + LOAD_GUARD_CYC);	// Surely programming
	localparam logic [TMR_W-1:0] PROG_LIM   = TMR_W'(PROG_CYC);

	main_e                      st_q;				// Sequence state
	logic [2:0]                 seq_idx_q;			// Step within a command sequence
	logic [ADDR_W-1:0]          wr_addr_q;			// Last byte loaded
	logic [DATA_W-1:0]          wr_data_q;			// Its data
	logic [ADDR_W-PAGE_LSB-1:0] pg_q;				// Page of the first byte
	logic                       last_q;				// Page closes after this byte
	logic [CNT_W-1:0]           cnt_q;				// Bytes loaded in this page
	logic [TMR_W-1:0]           load_tmr_q;			// Cycles since last write start
	logic [TMR_W-1:0]           wait_tmr_q;			// Cycles spent polling or waiting
	logic                       prev_b6_q;			// Toggle bit of previous poll
	logic                       have_prev_q;		// A previous poll exists
	logic                       eng_start_q;		// Pin cycle request
	logic                       eng_wr_q;			// Request is a write
	logic [ADDR_W-1:0]          eng_addr_q;			// Request address
	logic [DATA_W-1:0]          eng_data_q;			// Request data
	logic                       eng_idle;			// Pin engine free
	logic                       eng_done;			// Pin cycle finished
	logic [DATA_W-1:0]          eng_rdata;			// Data of finished read
	logic                       eng_free;			// Free and nothing queued
	logic                       window_open;		// Next byte may still start
	logic                       accept;				// Command taken this cycle
	logic                       stable;				// Programming seen complete

	assign eng_free    = eng_idle && !eng_start_q;
	assign window_open = (load_tmr_q < OPEN_LIM);		// RL11
	assign accept      = cmd_valid && cmd_ready;
	assign busy        = (st_q != M_IDLE);
	assign stable      = have_prev_q && (eng_rdata[TOGGLE_BIT] == prev_b6_q)	// RL15
	                     && (eng_rdata[POLL_BIT] == wr_data_q[POLL_BIT]);	// RL13

	// ----------------------------------------------------------------
	// Command acceptance
	// ----------------------------------------------------------------
	// Idle takes any legal op; a page takes only same-page writes in time
	always_comb begin
		cmd_ready = 1'b0;
		unique case (st_q)
			M_IDLE: cmd_ready = (cmd_op inside {OP_READ, OP_WRITE, OP_CLEAR});
			M_LOAD: cmd_ready = eng_free && !last_q && window_open	// RL11
			                    && (cnt_q < CNT_W'(PAGE_BYTES))		// RL9
			                    && (cmd_op == OP_WRITE) && !cmd_protect	// RL23
			                    && (page_of(cmd_addr) == pg_q);		// RL10
			default: cmd_ready = 1'b0;
		endcase
	end

	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------
	// State, pin requests and answers
	always_ff @(posedge mclk) begin
		if (rst) begin
			st_q        <= M_IDLE;
			seq_idx_q   <= '0;
			wr_addr_q   <= '0;
			wr_data_q   <= '0;
			pg_q        <= '0;
			last_q      <= 1'b0;
			prev_b6_q   <= 1'b0;
			have_prev_q <= 1'b0;
			eng_start_q <= 1'b0;
			eng_wr_q    <= 1'b0;
			eng_addr_q  <= '0;
			eng_data_q  <= '0;
			rsp_valid   <= 1'b0;
			rsp_rdata   <= '0;
			rsp_timeout <= 1'b0;
		end else begin
			eng_start_q <= 1'b0;
			rsp_valid   <= 1'b0;
			unique case (st_q)
				// Wait for a command
				M_IDLE: if (accept) begin
					wr_addr_q   <= cmd_addr;
					wr_data_q   <= cmd_wdata;
					last_q      <= cmd_last;
					pg_q        <= page_of(cmd_addr);
					seq_idx_q   <= '0;
					eng_start_q <= 1'b1;
					eng_wr_q    <= (cmd_op != OP_READ);
					eng_addr_q  <= cmd_addr;
					eng_data_q  <= cmd_wdata;
					if (cmd_op == OP_READ)
						st_q <= M_READ;
					else if (cmd_op == OP_CLEAR) begin
						eng_addr_q <= CLEAR_ADDR[0];		// RL24
						eng_data_q <= CLEAR_DATA[0];
						st_q       <= M_CLEAR;			// RL22
					end else if (cmd_protect) begin
						eng_addr_q <= UNLOCK_ADDR[0];	// RL24
						eng_data_q <= UNLOCK_DATA[0];
						st_q       <= M_UNLOCK;			// RL19
					end else
						st_q <= M_LOAD;
				end
				// Plain read answered once the data bus has been released
				M_READ: if (eng_done) begin
					rsp_valid   <= 1'b1;
					rsp_rdata   <= eng_rdata;
					rsp_timeout <= 1'b0;
					st_q        <= M_IDLE;
				end
				// Unlock writes then the held byte at once
				M_UNLOCK: if (eng_done) begin
					eng_start_q <= 1'b1;
					if (seq_idx_q == 3'(UNLOCK_LEN - 1)) begin
						eng_addr_q <= wr_addr_q;			// RL21
						eng_data_q <= wr_data_q;
						st_q       <= M_LOAD;			// RL20
					end else begin
						seq_idx_q  <= seq_idx_q + 3'd1;
						eng_addr_q <= UNLOCK_ADDR[seq_idx_q + 3'd1];
						eng_data_q <= UNLOCK_DATA[seq_idx_q + 3'd1];
					end
				end
				// Further bytes of the page, or close it
				M_LOAD: if (accept) begin
					wr_addr_q   <= cmd_addr;
					wr_data_q   <= cmd_wdata;
					last_q      <= cmd_last;
					eng_start_q <= 1'b1;
					eng_addr_q  <= cmd_addr;
					eng_data_q  <= cmd_wdata;
				end else if (eng_free && (last_q || !window_open || cmd_valid
				             || cnt_q == CNT_W'(PAGE_BYTES)))
					st_q <= M_SETTLE;					// RL11
				// Let the load window lapse so programming has begun
				M_SETTLE: if (load_tmr_q >= SETTLE_LIM) begin
					eng_start_q <= 1'b1;
					eng_wr_q    <= 1'b0;
					eng_addr_q  <= wr_addr_q;			// RL12
					have_prev_q <= 1'b0;
					st_q        <= M_POLL;
				end
				// Status reads until toggling stops and true data returns, or the poll limit PROG_LIM is reached
				M_POLL: if (eng_done) begin
					if (stable || wait_tmr_q >= PROG_LIM) begin
						rsp_valid   <= 1'b1;
						rsp_rdata   <= eng_rdata;
						rsp_timeout <= !stable;			// RL14
						st_q        <= M_IDLE;			// RL8
					end else begin
						prev_b6_q   <= eng_rdata[TOGGLE_BIT];
						have_prev_q <= 1'b1;
						eng_start_q <= 1'b1;
					end
				end
				// Six clearing writes
				M_CLEAR: if (eng_done) begin
					if (seq_idx_q == 3'(CLEAR_LEN - 1))
						st_q <= M_WAIT;
					else begin
						seq_idx_q   <= seq_idx_q + 3'd1;
						eng_start_q <= 1'b1;
						eng_addr_q  <= CLEAR_ADDR[seq_idx_q + 3'd1];
						eng_data_q  <= CLEAR_DATA[seq_idx_q + 3'd1];
					end
				end
				// Standard mode returns after program_cycle_time
				M_WAIT: if (wait_tmr_q >= PROG_LIM) begin
					rsp_valid   <= 1'b1;
					rsp_timeout <= 1'b0;
					st_q        <= M_IDLE;				// RL22
				end
				default: st_q <= M_IDLE;
			endcase
		end
	end

	// Byte count of the open page
	always_ff @(posedge mclk) begin
		if (rst || st_q == M_IDLE)
			cnt_q <= '0;
		else if (eng_start_q && eng_wr_q && st_q == M_LOAD)
			cnt_q <= cnt_q + CNT_W'(1);				// RL9
	end

	// Load window timer, restarted by every write
	always_ff @(posedge mclk) begin
		if (rst || (eng_start_q && eng_wr_q))
			load_tmr_q <= '0;
		else if (load_tmr_q != '1)
			load_tmr_q <= load_tmr_q + TMR_W'(1);
	end

	// Poll and clear timer
	always_ff @(posedge mclk) begin
		if (rst || !(st_q inside {M_POLL, M_WAIT}))
			wait_tmr_q <= '0;
		else if (wait_tmr_q != '1)
			wait_tmr_q <= wait_tmr_q + TMR_W'(1);
	end

	// ----------------------------------------------------------------
	// Pin engine
	// ----------------------------------------------------------------
	pin_cycle u_pins (
		.mclk  (mclk),
		.rst   (rst),
		.start (eng_start_q),
		.wr    (eng_wr_q),
		.addr  (eng_addr_q),
		.wdata (eng_data_q),
		.idle  (eng_idle),
		.done  (eng_done),
		.rdata (eng_rdata),
		.a     (mem_addr),
		.ce_n  (mem_ce_n),
		.oe_n  (mem_oe_n),
		.we_n  (mem_we_n),
		.dq_i  (mem_dq_i),
		.dq_o  (mem_dq_o),
		.dq_oe (mem_dq_oe)
	);

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	a_idle_deselect: assert property (st_q == M_IDLE && eng_free |-> mem_ce_n)	// RL2
		else $error("memory selected while idle");
	a_page_same: assert property (eng_start_q && eng_wr_q && st_q == M_LOAD	// RL10
		|-> page_of(eng_addr_q) == pg_q)
		else $error("page byte outside first page");
	a_page_max: assert property (cnt_q <= CNT_W'(PAGE_BYTES))	// RL9
		else $error("page load over limit");
	a_load_gap: assert property (eng_start_q && eng_wr_q && st_q == M_LOAD	// RL11
		&& cnt_q != '0 |-> load_tmr_q < TMR_W'(BLC_CYC))
		else $error("byte load started after window");
	a_settle_poll: assert property (st_q == M_SETTLE ##1 st_q == M_POLL	// RL11
		|-> $past(load_tmr_q) >= SETTLE_LIM && eng_start_q && !eng_wr_q)
		else $error("poll began inside load window");
	a_unlock_data: assert property (st_q == M_UNLOCK ##1 st_q != M_UNLOCK	// RL21
		|-> st_q == M_LOAD && eng_start_q && eng_addr_q == wr_addr_q
		&& $past(seq_idx_q) == 3'(UNLOCK_LEN - 1))
		else $error("unlock not followed by data write");
	a_unlock_addr: assert property (st_q == M_UNLOCK && eng_start_q	// RL24
		|-> eng_wr_q && eng_addr_q == UNLOCK_ADDR[seq_idx_q])
		else $error("unlock write to wrong address");
	a_clear_wait: assert property (st_q == M_WAIT && wait_tmr_q < PROG_LIM	// RL22
		|=> st_q == M_WAIT && !rsp_valid)
		else $error("clear answered before program time");
	a_poll_read: assert property (st_q == M_POLL && eng_start_q	// RL12
		|-> !eng_wr_q && eng_addr_q == wr_addr_q)
		else $error("poll is not a read of last byte");

	c_page_done: cover property (st_q == M_POLL && eng_done && stable && cnt_q > CNT_W'(1));
	c_clear_done: cover property (st_q == M_WAIT ##1 st_q == M_IDLE);
	c_protect_page: cover property (st_q == M_UNLOCK ##1 st_q == M_LOAD);
	c_poll_timeout: cover property (rsp_valid && rsp_timeout);

endmodule

// file: logic/eeprom_host_pkg.sv
// ----------------------------------------------------------------
// Shared constants for the byte-wide memory host
// ----------------------------------------------------------------
package eeprom_host_pkg;

	// Array geometry
	localparam int ADDR_W      = 15;		// Byte address lines
	localparam int DATA_W      = 8;			// Data lines
	localparam int PAGE_LSB    = 6;			// First page address bit
	localparam int PAGE_BYTES  = 64;		// Bytes in one page load
	localparam int CNT_W       = 7;			// Byte counter width
	localparam int TMR_W       = 24;		// Long timer width
	localparam int PHASE_W     = 8;			// Pin phase counter width
	localparam int TOGGLE_BIT  = 6;			// Bit that flips per status read
	localparam int POLL_BIT    = 7;			// Bit that reads inverted while busy

	// Command sequences
	localparam int UNLOCK_LEN  = 3;			// Writes that open a protected page
	localparam int CLEAR_LEN   = 6;			// Writes that drop protection
	localparam int SYNC_STAGES = 2;			// Flops on the data input

	// Clock and pin timing, in their own units
	localparam int CLK_PERIOD_NS = 10;		// mclk period
	localparam int T_OES_NS      = 10;		// Output gate high before strobe
	localparam int T_WP_NS       = 100;		// Write strobe low width
	localparam int T_AH_NS       = 150;		// Address hold from strobe fall
	localparam int T_WPH_NS      = 200;		// Strobe high recovery
	localparam int T_ACC_NS      = 350;		// Read access, slowest grade
	localparam int T_HZ_NS       = 50;		// Data bus release after read
	localparam int T_BLC_US      = 100;		// Byte load window, longest
	localparam int T_WC_MS       = 10;		// program_cycle_time, longest
	localparam int LOAD_GUARD_CYC = 16;		// Margin around the load window

	// Least time to whole cycles, never below one
	function automatic int cyc_up(input int ns);
		int c;
		c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
		return (c < 1) ? 1 : c;
	endfunction

	localparam int OES_CYC = cyc_up(T_OES_NS);
	localparam int WP_CYC  = cyc_up(T_WP_NS);
	localparam int AH_CYC  = cyc_up(T_AH_NS - T_WP_NS);
	localparam int WPH_CYC = cyc_up(T_WPH_NS);
	localparam int ACC_CYC = cyc_up(T_ACC_NS) + SYNC_STAGES;
	localparam int HZ_CYC  = cyc_up(T_HZ_NS);
	localparam int BLC_CYC_DEF = (T_BLC_US * 1000) / CLK_PERIOD_NS;
	localparam int WC_CYC_DEF  = cyc_up(T_WC_MS * 1000000);

	// Host command codes
	typedef enum logic [1:0] {
		OP_READ  = 2'b00,
		OP_WRITE = 2'b01,
		OP_CLEAR = 2'b10
	} op_e;

	// Page number of a byte address
	function automatic logic [ADDR_W-PAGE_LSB-1:0] page_of(input logic [ADDR_W-1:0] a);
		return a[ADDR_W-1:PAGE_LSB];
	endfunction

endpackage

// file: logic/pin_cycle.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// One read or one strobe-controlled write on the memory pins
// ----------------------------------------------------------------
module pin_cycle import eeprom_host_pkg::*; (
	// Clock and reset
	input  wire logic              mclk,
	input  wire logic              rst,
	// Request
	input  wire logic              start,
	input  wire logic              wr,
	input  wire logic [ADDR_W-1:0] addr,
	input  wire logic [DATA_W-1:0] wdata,
	output logic                   idle,
	output logic                   done,
	output logic [DATA_W-1:0]      rdata,
	// Memory pins
	output logic [ADDR_W-1:0]      a,
	output logic                   ce_n,
	output logic                   oe_n,
	output logic                   we_n,
	input  wire logic [DATA_W-1:0] dq_i,
	output logic [DATA_W-1:0]      dq_o,
	output logic                   dq_oe
);

	localparam int WE_LAST = WP_CYC - 1;		// Strobe low cycles after the fall

	typedef enum logic [2:0] {
		E_IDLE    = 3'b000,
		E_SETUP   = 3'b001,
		E_STROBE  = 3'b010,
		E_HOLD    = 3'b011,
		E_REC     = 3'b100,
		E_ACCESS  = 3'b101,
		E_RELEASE = 3'b110
	} eng_e;

	eng_e               st_q, st_d;				// Phase
	logic [PHASE_W-1:0] cnt_q, cnt_d;			// Cycles spent in phase
	logic [DATA_W-1:0]  dq_s1_q, dq_s2_q;		// Data input synchroniser
	logic               last;					// Final cycle of phase

	// Cycles each phase lasts
	function automatic logic [PHASE_W-1:0] phase_len(input eng_e s);
		unique case (s)
			E_SETUP:   return PHASE_W'(OES_CYC);
			E_STROBE:  return PHASE_W'(WP_CYC);
			E_HOLD:    return PHASE_W'(AH_CYC);
			E_REC:     return PHASE_W'(WPH_CYC);
			E_ACCESS:  return PHASE_W'(ACC_CYC);
			E_RELEASE: return PHASE_W'(HZ_CYC);
			default:   return PHASE_W'(1);
		endcase
	endfunction

	assign last = (cnt_q == phase_len(st_q) - PHASE_W'(1));
	assign idle = (st_q == E_IDLE);

	// Phase sequencing
	always_comb begin
		st_d  = st_q;
		cnt_d = last ? '0 : cnt_q + PHASE_W'(1);
		unique case (st_q)
			E_IDLE: begin
				cnt_d = '0;
				if (start)
					st_d = wr ? E_SETUP : E_ACCESS;
			end
			E_SETUP:   if (last) st_d = E_STROBE;
			E_STROBE:  if (last) st_d = E_HOLD;
			E_HOLD:    if (last) st_d = E_REC;
			E_REC:     if (last) st_d = E_IDLE;
			E_ACCESS:  if (last) st_d = E_RELEASE;
			E_RELEASE: if (last) st_d = E_IDLE;
			default:   st_d = E_IDLE;
		endcase
	end

	// Phase registers
	always_ff @(posedge mclk) begin
		if (rst) begin
			st_q  <= E_IDLE;
			cnt_q <= '0;
		end else begin
			st_q  <= st_d;
			cnt_q <= cnt_d;
		end
	end

	// Control pins follow the next phase; write only with output gate high
	always_ff @(posedge mclk) begin
		if (rst) begin
			ce_n  <= 1'b1;
			oe_n  <= 1'b1;
			we_n  <= 1'b1;
			dq_oe <= 1'b0;
		end else begin
			ce_n  <= !(st_d inside {E_SETUP, E_STROBE, E_HOLD, E_ACCESS});	// RL2
			oe_n  <= (st_d != E_ACCESS);									// RL12
			we_n  <= (st_d != E_STROBE);									// RL5
			dq_oe <= (st_d inside {E_SETUP, E_STROBE, E_HOLD});			// RL17
		end
	end

	// Address and write data latched at request
	always_ff @(posedge mclk) begin
		if (rst) begin
			a    <= '0;
			dq_o <= '0;
		end else if (start && idle) begin
			a    <= addr;
			dq_o <= wdata;
		end
	end

	// Two-flop data input, read data taken at end of access
	always_ff @(posedge mclk) begin
		if (rst) begin
			dq_s1_q <= '0;
			dq_s2_q <= '0;
			rdata   <= '0;
			done    <= 1'b0;
		end else begin
			dq_s1_q <= dq_i;
			dq_s2_q <= dq_s1_q;
			if (st_q == E_ACCESS && last)
				rdata <= dq_s2_q;
			done <= last && (st_q inside {E_REC, E_RELEASE});
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	a_we_gate_excl: assert property (@(posedge mclk) disable iff (rst)	// RL5
		!we_n |-> oe_n && !ce_n && dq_oe)
		else $error("write strobe low without select or with gate low");
	a_we_width_min: assert property (@(posedge mclk) disable iff (rst)	// RL16
		$fell(we_n) |-> ##WE_LAST !we_n ##1 we_n)
		else $error("write strobe pulse width wrong");
	a_read_no_drive: assert property (@(posedge mclk) disable iff (rst)	// RL12
		!oe_n |-> !dq_oe && !ce_n && we_n)
		else $error("host drives data during a read");

endmodule

// file: dv/eeprom_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Behavioural byte-wide memory standing on the host's pins
// ----------------------------------------------------------------
module eeprom_model import eeprom_host_pkg::*; #(
	parameter int BLC_NS = 2000,	// Byte load window
	parameter logic [UNLOCK_LEN-1:0][ADDR_W-1:0] UA = '{15'h3, 15'h2, 15'h1},
	parameter logic [UNLOCK_LEN-1:0][DATA_W-1:0] UD = '{8'h3, 8'h2, 8'h1},
	parameter logic [CLEAR_LEN-1:0][ADDR_W-1:0] CA = '{15'h6, 15'h5, 15'h4, 15'h3, 15'h2, 15'h1},
	parameter logic [CLEAR_LEN-1:0][DATA_W-1:0] CD = '{8'h6, 8'h5, 8'h4, 8'h3, 8'h2, 8'h1}
) (
	// Pins from the host
	input  wire logic [ADDR_W-1:0] a,
	input  wire logic              ce_n,
	input  wire logic              oe_n,
	input  wire logic              we_n,
	input  wire logic [DATA_W-1:0] dq_o,
	input  wire logic              dq_oe,
	// Pins to the host
	output logic [DATA_W-1:0]      dq_i
);
	logic [7:0]  mem [0:32767];		// Array contents
	logic [14:0] q_a [$];			// Addresses of the open load
	logic [7:0]  q_d [$];			// Data of the open load
	logic [14:0] la      = '0;		// Latched address
	logic [7:0]  lw      = '0;		// Last byte loaded
	logic [7:0]  last_rd = '0;		// Last byte driven
	logic [7:0]  val;				// Byte a read would see
	logic        prot    = 1'b0;	// Shipped unprotected
	logic        busy    = 1'b0;	// Programming in progress
	logic        tog     = 1'b0;	// Toggling status bit
	logic        wact    = 1'b0;	// Write strobe overlap
	logic        unl, clr;			// Load starts with a sequence
	logic        rd;				// Read active
	int          prog_ns = 5000;	// Programming time, bench may stretch
	int          n_last  = 0;		// Bytes in the last load
	time         t_fall  = 0;		// Last write strobe fall
	initial begin
		foreach (mem[i]) mem[i] = 8'hff;
	end
	// Address taken at the later falling strobe, gate high
	always @(negedge ce_n or negedge we_n) begin
		if (!ce_n && !we_n && oe_n) begin
			la = a;
			t_fall = $time;
			wact = 1'b1;
		end
	end
	// Data taken at the earlier rising strobe; glitches dropped
	always @(posedge ce_n or posedge we_n) begin
		if (wact && !busy && ($time - t_fall >= 20)) begin
			q_a.push_back(la);
			q_d.push_back(dq_oe ? dq_o : ~dq_o);
		end
		wact = 1'b0;
	end
	// Load closes when the window lapses, then programming runs
	initial forever begin
		wait (q_a.size() > 0);
		while ($time - t_fall < BLC_NS) #10;
		n_last = q_a.size();
		lw = q_d[n_last-1];
		unl = (n_last >= UNLOCK_LEN);
		clr = (n_last == CLEAR_LEN);
		for (int i = 0; i < UNLOCK_LEN; i++)
			if (unl && (q_a[i] != UA[i] || q_d[i] != UD[i])) unl = 1'b0;
		for (int i = 0; i < CLEAR_LEN; i++)
			if (clr && (q_a[i] != CA[i] || q_d[i] != CD[i])) clr = 1'b0;
		// Protected loads without the sequence vanish silently
		if (clr || unl || !prot) begin
			busy = 1'b1;
			#(prog_ns);
			for (int i = unl ? UNLOCK_LEN : 0; i < n_last; i++)
				if (!clr) mem[q_a[i]] = q_d[i];
			prot = clr ? 1'b0 : (prot | unl);
			busy = 1'b0;
		end
		q_a.delete();
		q_d.delete();
	end
	// Status while busy, stored byte otherwise; bus never floats to a stale value
	assign rd  = !ce_n && !oe_n;
	assign val = busy ? {~lw[7], tog, lw[5:0]} : mem[a];
	always @(rd, val) if (rd) last_rd = val;
	always @(rd) if (!rd && busy) tog = ~tog;
	assign dq_i = rd ? val : ~last_rd;
endmodule

// file: dv/eeprom_host_bench.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Self-checking bench for the byte-wide memory host
// ----------------------------------------------------------------
module eeprom_host_bench import eeprom_host_pkg::*;;
	localparam int BLC = 200;				// Short load window
	logic              mclk = 1'b0;			// Clock
	logic              rst = 1'b1;			// Reset
	logic              cmd_valid = 1'b0;	// Command offered
	op_e               cmd_op = OP_READ;	// Command code
	logic [ADDR_W-1:0] cmd_addr = '0;		// Byte address
	logic [DATA_W-1:0] cmd_wdata = '0;		// Write data
	logic              cmd_last = 1'b0;		// Page closes
	logic              cmd_protect = 1'b0;	// Unlock first
	logic              cmd_ready, rsp_valid, rsp_timeout, busy;
	logic [DATA_W-1:0] rsp_rdata, mem_dq_i, mem_dq_o;
	logic [ADDR_W-1:0] mem_addr;
	logic              mem_ce_n, mem_oe_n, mem_we_n, mem_dq_oe;
	int                fails = 0;
	int                samples_checked = 0;
	eeprom_host #(.BLC_CYC(BLC), .PROG_CYC(2000)) eeprom_host_inst (.mclk(mclk), .rst(rst),
		.cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_addr(cmd_addr),
		.cmd_wdata(cmd_wdata), .cmd_last(cmd_last), .cmd_protect(cmd_protect),
		.rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .rsp_timeout(rsp_timeout), .busy(busy),
		.mem_addr(mem_addr), .mem_ce_n(mem_ce_n), .mem_oe_n(mem_oe_n), .mem_we_n(mem_we_n),
		.mem_dq_i(mem_dq_i), .mem_dq_o(mem_dq_o), .mem_dq_oe(mem_dq_oe));
	eeprom_model #(.BLC_NS(BLC * 10)) eeprom_model_inst (.a(mem_addr), .ce_n(mem_ce_n),
		.oe_n(mem_oe_n), .we_n(mem_we_n), .dq_o(mem_dq_o), .dq_oe(mem_dq_oe), .dq_i(mem_dq_i));
	initial forever #5 mclk = ~mclk;
	// Compare and count
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// Verdict and end of run
	task automatic summarize();
		$display("checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	// Offer a command at a falling edge and hold it until taken
	task automatic send(input op_e op, input logic [14:0] ad, input logic [7:0] d,
			input logic last, input logic pr);
		int n = 0;
		@(negedge mclk);
		cmd_op = op;
		cmd_addr = ad;
		cmd_wdata = d;
		cmd_last = last;
		cmd_protect = pr;
		cmd_valid = 1'b1;
		while (cmd_ready !== 1'b1 && n < 20000) begin
			@(negedge mclk);
			n++;
		end
		if (n >= 20000) begin
			fails++;
			summarize();
		end
		@(negedge mclk);
		cmd_valid = 1'b0;
	endtask
	// Bounded wait for the one-cycle answer
	task automatic wait_rsp();
		int n = 0;
		while (rsp_valid !== 1'b1 && n < 20000) begin
			@(negedge mclk);
			n++;
		end
		if (n >= 20000) begin
			fails++;
			summarize();
		end
		@(negedge mclk);
	endtask
	// Read one byte and compare
	task automatic rd_chk(input logic [14:0] ad, input logic [7:0] exp);
		send(OP_READ, ad, 8'h00, 1'b0, 1'b0);
		wait_rsp();
		check("read data", rsp_rdata, exp);
	endtask
	// Pins idle after reset
	task automatic t_idle();
		check("strobes", {mem_ce_n, mem_oe_n, mem_we_n}, 3'b111);
		check("bus drive", mem_dq_oe, 1'b0);
		check("busy ready", {busy, cmd_ready}, 2'b01);
		$display("test idle done");
	endtask
	// Byte at the top address, then read back
	task automatic t_byte();
		send(OP_WRITE, 15'h7fff, 8'ha5, 1'b1, 1'b0);
		wait_rsp();
		check("byte timeout", rsp_timeout, 1'b0);
		check("byte stored", eeprom_model_inst.mem[15'h7fff], 8'ha5);
		rd_chk(15'h7fff, 8'ha5);
		$display("test byte done");
	endtask
	// Full page of 64 bytes back to back
	task automatic t_page();
		for (int i = 0; i < 64; i++)
			send(OP_WRITE, {9'h0a5, 6'(i)}, 8'(i) ^ 8'h3c, i == 63, 1'b0);
		wait_rsp();
		check("page count", 16'(eeprom_model_inst.n_last), 16'd64);
		for (int i = 0; i < 64; i++)
			check("page byte", eeprom_model_inst.mem[{9'h0a5, 6'(i)}], 8'(i) ^ 8'h3c);
		rd_chk({9'h0a5, 6'h3f}, 8'h03);
		$display("test page done");
	endtask
	// Protect, refused write, clear, then open access
	task automatic t_protect();
		send(OP_WRITE, 15'h0123, 8'h5a, 1'b1, 1'b1);
		wait_rsp();
		check("protected", eeprom_model_inst.prot, 1'b1);
		check("unlocked byte", eeprom_model_inst.mem[15'h0123], 8'h5a);
		send(OP_WRITE, 15'h0124, 8'h33, 1'b1, 1'b0);
		wait_rsp();
		check("no polling", rsp_timeout, 1'b1);
		check("blocked byte", eeprom_model_inst.mem[15'h0124], 8'hff);
		send(OP_CLEAR, 15'h0000, 8'h00, 1'b0, 1'b0);
		wait_rsp();
		check("cleared", eeprom_model_inst.prot, 1'b0);
		send(OP_WRITE, 15'h0124, 8'h33, 1'b1, 1'b0);
		wait_rsp();
		rd_chk(15'h0124, 8'h33);
		$display("test protect done");
	endtask
	// Programming slower than the poll limit
	task automatic t_slow();
		int n = 0;
		eeprom_model_inst.prog_ns = 30000;
		send(OP_WRITE, 15'h4000, 8'hc3, 1'b1, 1'b0);
		wait_rsp();
		check("slow timeout", rsp_timeout, 1'b1);
		while (eeprom_model_inst.busy && n < 5000) begin
			@(negedge mclk);
			n++;
		end
		check("slow settle", eeprom_model_inst.busy, 1'b0);
		eeprom_model_inst.prog_ns = 5000;
		rd_chk(15'h4000, 8'hc3);
		$display("test slow done");
	endtask
	initial begin
		repeat (20) @(negedge mclk);
		rst = 1'b0;
		@(negedge mclk);
		t_idle();
		t_byte();
		t_page();
		t_protect();
		t_slow();
		summarize();
	end
endmodule
